// ===== core/ddi_defines.vh
// shared constants of the dual converter input front end
// assumes inclusion by bare name from the pipe and top design files of the block
`ifndef DDI_DEFINES_VH
`define DDI_DEFINES_VH

// sample word width, offset binary
`define DDI_DATA_W        12
// write strobe to converter output, in update clock edges
`define DDI_LATENCY       4
// output buffer depth, in words
`define DDI_FIFO_DEPTH    16
// strap level that selects dual-bus mode
`define DDI_MODE_DUAL     1'b1
// reset value of every sample register (code zero, minimum output)
`define DDI_SAMPLE_RST    12'h000
// reset value of the divided converter clock
`define DDI_DIVCLK_RST    1'b0
// buffered word layout: {q update, i update, q word, i word}
`define DDI_WORD_I_LSB    0
`define DDI_WORD_Q_LSB    12
`define DDI_WORD_UPD_I    24
`define DDI_WORD_UPD_Q    25
`define DDI_WORD_W        26

`endif

// ===== core/ddi_fifo.v
// synchronous first-in first-out buffer with valid and ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module ddi_fifo #(
   parameter WIDTH = 26,                      // word width
   parameter DEPTH = 16,                      // number of words
   parameter AW    = 4                        // address width, log2 of depth
) (
   input  wire             clk_i,             // block clock
   input  wire             rst_n_i,           // synchronous reset, low active
   input  wire             in_valid_i,        // word offered on fill side
   output wire             in_ready_o,        // room for one more word
   input  wire [WIDTH-1:0] in_data_i,         // word to store
   output wire             out_valid_o,       // a word is waiting
   input  wire             out_ready_i,       // drain side takes the word
   output wire [WIDTH-1:0] out_data_o         // oldest stored word
);

   reg  [WIDTH-1:0] mem [0:DEPTH-1];          // storage flops
   reg  [AW-1:0]    wr_ptr;                   // next write slot
   reg  [AW-1:0]    rd_ptr;                   // oldest slot
   reg  [AW:0]      count;                    // words held
   wire             do_push;                  // accepted write
   wire             do_pop;                   // accepted read

   // full and empty come straight from the count, so both are exact
   assign in_ready_o  = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign do_push     = in_valid_i & in_ready_o;
   assign do_pop      = out_valid_o & out_ready_i;
   assign out_data_o  = mem[rd_ptr];

   // storage is written only, never reset: contents are masked by count
   always @(posedge clk_i)
   begin
      if (do_push)
      begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // pointers wrap naturally since depth is a power of two
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (do_push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (do_push & ~do_pop)
         begin
            count <= count + 1'b1;
         end
         else if (do_pop & ~do_push)
         begin
            count <= count - 1'b1;
         end
      end
   end

endmodule // ddi_fifo

`default_nettype wire

// ===== core/ddi_pipe.v
// fixed-depth sample pipeline advanced by an enable pulse
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "ddi_defines.vh"

module ddi_pipe #(
   parameter WIDTH = 12,                      // sample width
   parameter DEPTH = 4                        // stages between latch and output
) (
   input  wire             clk_i,             // block clock
   input  wire             rst_n_i,           // synchronous reset, low active
   input  wire             adv_i,             // one-cycle advance pulse
   input  wire [WIDTH-1:0] d_i,               // word entering first stage
   output wire [WIDTH-1:0] q_o                // word leaving last stage
);

   wire [WIDTH-1:0] tap [0:DEPTH];            // stage outputs, tap 0 is input

   assign tap[0] = d_i;
   assign q_o    = tap[DEPTH];

   genvar s;
   generate
      for (s = 0; s < DEPTH; s = s + 1)
      begin : g_stage
         reg [WIDTH-1:0] stage;               // one converter latch stage
         // every stage moves together, so latency is exactly depth edges
         always @(posedge clk_i)
         begin
            if (!rst_n_i)
            begin
               stage <= `DDI_SAMPLE_RST;
            end
            else if (adv_i)
            begin
               stage <= tap[s];
            end
         end
         assign tap[s+1] = stage;
      end
   endgenerate

endmodule // ddi_pipe

`default_nettype wire

// ===== core/ddi_top.v
// input front end of a dual-channel 12-bit converter: dual-bus and interleaved modes
// assumes every pin input is synchronous to clk_i and that strobes are far slower
// than clk_i, so each rising or falling edge is seen as a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "ddi_defines.vh"

// Notes on behaviour
// R1: sample reaches outputs four update edges later
// R2: words taken with straight weight, top bit msb
// R3: offset binary, code zero is minimum output
// R4: strap high dual bus, low interleaved
// R5: dual bus channels run fully independently; here both share one stall and one output buffer
// R6: write rise latches, update clock moves latch
// R7: host keeps write and clock periods equal
// R8: interleaved words on channel one bus only
// R9: select high feeds i latch, low q
// R10: unselected latch recirculates its own value
// R11: host sends words at twice update rate
// R12: capture on write rise, forward on fall
// R13: shared clock divided by two internally
// R14: align reset holds divided clock low
// R15: align reset fixes i and q pairing
// R16: host stays within update rate limit
// R17: first divided rise follows an i capture
module ddi_top #(
   parameter DATA_W     = `DDI_DATA_W,        // sample width
   parameter LATENCY    = `DDI_LATENCY,       // update edges from write to output
   parameter FIFO_DEPTH = `DDI_FIFO_DEPTH,    // output buffer depth
   parameter FIFO_AW    = 4                   // log2 of buffer depth
) (
   input  wire              clk_i,                    // block clock, 20 MHz
   input  wire              rst_n_i,                  // synchronous reset, low active
   input  wire              mode_dual_i,              // static strap, high dual bus
   input  wire [DATA_W-1:0] data_chan_one_i,          // channel one bus, shared bus in interleaved mode
   input  wire [DATA_W-1:0] data_chan_two_i,          // channel two bus
   input  wire              write_strobe_chan_one_i,  // channel one write strobe
   input  wire              write_strobe_chan_two_i,  // channel two write strobe
   input  wire              update_clock_chan_one_i,  // channel one update clock
   input  wire              update_clock_chan_two_i,  // channel two update clock
   input  wire              shared_write_strobe_i,    // interleaved write strobe
   input  wire              shared_update_clock_i,    // interleaved update clock
   input  wire              channel_select_i,         // high steers word to i
   input  wire              interleave_align_reset_i, // high holds divided clock low
   input  wire              out_ready_i,              // converter core takes a word
   output wire              out_valid_o,              // buffered word waiting
   output wire [DATA_W-1:0] out_data_i_o,             // buffered i word
   output wire [DATA_W-1:0] out_data_q_o,             // buffered q word
   output wire              out_upd_i_o,              // i word is fresh in this entry
   output wire              out_upd_q_o,              // q word is fresh in this entry
   output wire [DATA_W-1:0] conv_i_o,                 // i converter latch
   output wire [DATA_W-1:0] conv_q_o,                 // q converter latch
   output wire              conv_update_o,            // converter latches moved
   output wire              divided_converter_clock_o,// internal divided clock
   output wire              host_ready_o              // low while the block stalls
);

   // ---------------------------------------------------------------
   // strap and edge history
   // ---------------------------------------------------------------
   reg              mode_dual;                // registered strap level
   reg              wr1_prev;                 // last channel one strobe
   reg              wr2_prev;                 // last channel two strobe
   reg              ck1_prev;                 // last channel one clock
   reg              ck2_prev;                 // last channel two clock
   reg              wrs_prev;                 // last shared strobe
   reg              cks_prev;                 // last shared clock
   wire             wr1_rise;                 // channel one write edge
   wire             wr2_rise;                 // channel two write edge
   wire             ck1_rise;                 // channel one clock edge
   wire             ck2_rise;                 // channel two clock edge
   wire             wrs_rise;                 // shared write rising edge
   wire             wrs_fall;                 // shared write falling edge
   wire             cks_rise;                 // shared clock rising edge

   // the strap is static, so sampling it every cycle costs nothing and
   // keeps reset free of port values
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         mode_dual <= `DDI_MODE_DUAL;
         wr1_prev  <= 1'b0;
         wr2_prev  <= 1'b0;
         ck1_prev  <= 1'b0;
         ck2_prev  <= 1'b0;
         wrs_prev  <= 1'b0;
         cks_prev  <= 1'b0;
      end
      else
      begin
         mode_dual <= mode_dual_i;                 // [R4]
         wr1_prev  <= write_strobe_chan_one_i;
         wr2_prev  <= write_strobe_chan_two_i;
         ck1_prev  <= update_clock_chan_one_i;
         ck2_prev  <= update_clock_chan_two_i;
         wrs_prev  <= shared_write_strobe_i;
         cks_prev  <= shared_update_clock_i;
      end
   end

   assign wr1_rise = write_strobe_chan_one_i & ~wr1_prev;
   assign wr2_rise = write_strobe_chan_two_i & ~wr2_prev;
   assign ck1_rise = update_clock_chan_one_i & ~ck1_prev;
   assign ck2_rise = update_clock_chan_two_i & ~ck2_prev;
   assign wrs_rise = shared_write_strobe_i & ~wrs_prev;
   assign wrs_fall = ~shared_write_strobe_i & wrs_prev;
   assign cks_rise = shared_update_clock_i & ~cks_prev;

   // ---------------------------------------------------------------
   // stall control from the output buffer
   // ---------------------------------------------------------------
   wire             fifo_in_ready;            // buffer has room
   reg              push_pend;                // a push is due this cycle
   wire             stall;                    // hold every latch still

   // a push follows each advance one cycle later; blocking an advance
   // while that push is pending keeps the buffer from overflowing
   assign stall        = ~fifo_in_ready | push_pend;
   assign host_ready_o = ~stall;

   // ---------------------------------------------------------------
   // divided converter clock for interleaved mode
   // ---------------------------------------------------------------
   reg              div_clk;                  // shared clock divided by two
   wire             div_rise;                 // divided clock about to rise

   // the rise is taken from the current phase so the pipes advance in
   // the same cycle the divided clock goes high
   assign div_rise = ~mode_dual & cks_rise & ~div_clk
                   & ~interleave_align_reset_i & ~stall;

   // align reset forces the low phase; the first shared clock edge after
   // release is then always a rising edge of the divided clock
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         div_clk <= `DDI_DIVCLK_RST;
      end
      else if (mode_dual)
      begin
         div_clk <= 1'b0;                          // unused in dual bus
      end
      else if (interleave_align_reset_i)
      begin
         div_clk <= 1'b0;                          // [R14] [R15]
      end
      else if (cks_rise & ~stall)
      begin
         div_clk <= ~div_clk;                      // [R13]
      end
   end

   assign divided_converter_clock_o = div_clk;

   // ---------------------------------------------------------------
   // input latches
   // ---------------------------------------------------------------
   reg [DATA_W-1:0] in_lat_i;                 // i or channel one input latch
   reg [DATA_W-1:0] in_lat_q;                 // q or channel two input latch
   reg [DATA_W-1:0] fwd_i;                    // i word handed to pipe
   reg [DATA_W-1:0] fwd_q;                    // q word handed to pipe
   reg [DATA_W-1:0] next_lat_i;               // next i latch value
   reg [DATA_W-1:0] next_lat_q;               // next q latch value

   // words are moved as plain bit vectors: the top bit stays the msb and
   // no recoding happens, so offset binary reaches the core untouched
   always @*
   begin
      next_lat_i = in_lat_i;
      next_lat_q = in_lat_q;
      if (mode_dual)
      begin
         if (wr1_rise & ~stall)
         begin
            next_lat_i = data_chan_one_i;          // [R5] [R6] [R2] [R3]
         end
         if (wr2_rise & ~stall)
         begin
            next_lat_q = data_chan_two_i;          // [R5] [R6]
         end
      end
      else if (wrs_rise & ~stall)
      begin
         // only the channel one bus is looked at here
         if (channel_select_i)
         begin
            next_lat_i = data_chan_one_i;          // [R8] [R9] [R12]
            next_lat_q = in_lat_q;                 // [R10]
         end
         else
         begin
            next_lat_q = data_chan_one_i;          // [R8] [R9] [R12]
            next_lat_i = in_lat_i;                 // [R10]
         end
      end
   end

   // latch update on the write rising edge, interleaved forwarding on the write falling edge
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         in_lat_i <= `DDI_SAMPLE_RST;
         in_lat_q <= `DDI_SAMPLE_RST;
         fwd_i    <= `DDI_SAMPLE_RST;
         fwd_q    <= `DDI_SAMPLE_RST;
      end
      else
      begin
         in_lat_i <= next_lat_i;
         in_lat_q <= next_lat_q;
         if (~mode_dual & wrs_fall & ~stall)
         begin
            fwd_i <= in_lat_i;                     // [R12]
            fwd_q <= in_lat_q;                     // [R12]
         end
      end
   end

   // ---------------------------------------------------------------
   // converter pipelines, one per channel
   // ---------------------------------------------------------------
   wire [1:0]        adv;                     // per channel advance pulse
   wire [DATA_W-1:0] pipe_in  [0:1];          // word entering each pipe
   wire [DATA_W-1:0] pipe_out [0:1];          // converter latch of each pipe

   // dual bus: each channel follows its own clock; interleaved: both
   // follow the divided clock, which is what keeps i and q paired.
   // the host is expected to have made its i capture before that edge
   assign adv[0] = mode_dual ? (ck1_rise & ~stall) : div_rise;  // [R6] [R17]
   assign adv[1] = mode_dual ? (ck2_rise & ~stall) : div_rise;  // [R6] [R17]
   assign pipe_in[0] = mode_dual ? in_lat_i : fwd_i;
   assign pipe_in[1] = mode_dual ? in_lat_q : fwd_q;

   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1)
      begin : g_chan
         // write edge to output is fixed at latency edges in both modes
         ddi_pipe #(
            .WIDTH (DATA_W),
            .DEPTH (LATENCY)                       // [R1]
         ) u_pipe (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .adv_i   (adv[c]),
            .d_i     (pipe_in[c]),
            .q_o     (pipe_out[c])
         );
      end
   endgenerate

   assign conv_i_o = pipe_out[0];
   assign conv_q_o = pipe_out[1];

   // ---------------------------------------------------------------
   // hand the fresh converter words to the output buffer
   // ---------------------------------------------------------------
   reg  [1:0]               adv_d;            // which channels just moved
   wire [`DDI_WORD_W-1:0]   push_word;        // assembled buffer word
   wire [`DDI_WORD_W-1:0]   pop_word;         // word leaving buffer

   // a pending push is one cycle after an advance; stall blocks a
   // second advance meanwhile, so at most one push is ever in flight
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         adv_d     <= 2'b00;
         push_pend <= 1'b0;
      end
      else
      begin
         adv_d     <= adv;
         push_pend <= |adv;
      end
   end

   assign conv_update_o = push_pend;
   assign push_word     = {adv_d[1], adv_d[0], pipe_out[1], pipe_out[0]};

   ddi_fifo #(
      .WIDTH (`DDI_WORD_W),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (push_pend),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (push_word),
      .out_valid_o (out_valid_o),
      .out_ready_i (out_ready_i),
      .out_data_o  (pop_word)
   );

   assign out_data_i_o = pop_word[`DDI_WORD_I_LSB +: DATA_W];
   assign out_data_q_o = pop_word[`DDI_WORD_Q_LSB +: DATA_W];
   assign out_upd_i_o  = pop_word[`DDI_WORD_UPD_I];
   assign out_upd_q_o  = pop_word[`DDI_WORD_UPD_Q];

endmodule // ddi_top

`default_nettype wire

// ===== sim/ddi_props.sv
// checker of the converter input front end, seeing only the top module's ports
// assumes one clock and the synchronous low-active reset of ddi_top
`timescale 1ns/1ps
`default_nettype none
module ddi_props #(
   parameter DATA_W = 12                                  // sample width
) (
   input wire logic              clk_i,                    // block clock
   input wire logic              rst_n_i,                  // reset, low active
   input wire logic              mode_dual_i,              // mode strap
   input wire logic              interleave_align_reset_i, // alignment reset
   input wire logic              out_ready_i,              // drain ready
   input wire logic              out_valid_o,              // head valid
   input wire logic [DATA_W-1:0] out_data_i_o,             // head i word
   input wire logic              out_upd_i_o,              // head i fresh
   input wire logic              out_upd_q_o,              // head q fresh
   input wire logic [DATA_W-1:0] conv_i_o,                 // i latch
   input wire logic [DATA_W-1:0] conv_q_o,                 // q latch
   input wire logic              conv_update_o,            // latches moved
   input wire logic              divided_converter_clock_o // divided clock
);
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // interleaved divided-clock rise: one pair leaves the input latches
   sequence div_rise_s;
      !mode_dual_i ##1 $rose(divided_converter_clock_o);
   endsequence
   // three cycles is enough for the pin sampler to see the reset level
   divclk_held_a:
      assert property ((!mode_dual_i && interleave_align_reset_i) [*3] |-> !divided_converter_clock_o)
      else $error("divided clock high under align reset");
   divrise_gate_a:
      assert property ($rose(divided_converter_clock_o) |-> !$past(interleave_align_reset_i))
      else $error("divided clock rose while aligning");
   pair_update_a:
      assert property (div_rise_s |-> ##[0:2] conv_update_o)
      else $error("divided rise moved no latch");
   latch_move_a:
      assert property ($changed(conv_i_o) || $changed(conv_q_o) |-> ##[0:1] conv_update_o)
      else $error("latch changed without update");
   update_pulse_a:
      assert property (conv_update_o |=> !conv_update_o)
      else $error("update pulse longer than one cycle");
   push_seen_a:
      assert property (conv_update_o |=> out_valid_o)
      else $error("update not buffered");
   head_hold_a:
      assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_i_o))
      else $error("buffer head moved while stalled");
   iq_both_a:
      assert property (out_valid_o && !mode_dual_i |-> out_upd_i_o && out_upd_q_o)
      else $error("interleaved entry lacks a channel");
endmodule // ddi_props
bind ddi_top ddi_props #(.DATA_W(DATA_W)) u_ddi_props (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .mode_dual_i(mode_dual_i),
   .interleave_align_reset_i(interleave_align_reset_i), .out_ready_i(out_ready_i),
   .out_valid_o(out_valid_o), .out_data_i_o(out_data_i_o), .out_upd_i_o(out_upd_i_o),
   .out_upd_q_o(out_upd_q_o), .conv_i_o(conv_i_o), .conv_q_o(conv_q_o),
   .conv_update_o(conv_update_o), .divided_converter_clock_o(divided_converter_clock_o));
`default_nettype wire

// ===== sim/ddi_host.sv
// host model: drives sample words, strobes, clocks and the strap
// assumes its tasks are entered just after a falling edge of clk_i
`timescale 1ns/1ps
`default_nettype none
module ddi_host (
   input  wire logic        clk_i,                   // block clock
   input  wire logic        host_ready_i,            // block takes edges
   output var  logic        mode_dual_o,             // static strap
   output var  logic [11:0] data_chan_one_o,         // channel one or shared bus
   output var  logic [11:0] data_chan_two_o,         // channel two bus
   output var  logic        write_strobe_chan_one_o, // channel one write
   output var  logic        write_strobe_chan_two_o, // channel two write
   output wire logic        update_clock_chan_one_o, // channel one clock
   output wire logic        update_clock_chan_two_o, // channel two clock
   output var  logic        shared_write_strobe_o,   // interleaved write
   output var  logic        shared_update_clock_o,   // interleaved clock
   output var  logic        channel_select_o,        // high steers to i
   output var  logic        interleave_align_reset_o // pairs i with q
);
   logic ph; // a pair went out since alignment
   // clock tied to write, so its rise never trails the write rise
   assign update_clock_chan_one_o = write_strobe_chan_one_o;
   assign update_clock_chan_two_o = write_strobe_chan_two_o;
   // quiet pins at time zero, strap on dual bus
   initial
   begin
      {write_strobe_chan_one_o, write_strobe_chan_two_o, shared_write_strobe_o} = 3'h0;
      {shared_update_clock_o, channel_select_o, interleave_align_reset_o, ph} = 4'h0;
      {mode_dual_o, data_chan_one_o, data_chan_two_o} = {1'b1, 12'h000, 12'hfff};
   end
   // each level stands at least two clocks; an edge waits up to 64 clocks for a stall to end
   task automatic tick;
      int k;
      repeat (2) @(negedge clk_i);
      for (k = 0; k < 64 && host_ready_i !== 1'b1; k++)
         @(negedge clk_i);
   endtask
   // one write on the channels in m, words in offset binary
   task automatic dual_word(input logic [1:0] m, input logic [11:0] d);
      data_chan_one_o = m[0] ? d : data_chan_one_o;
      data_chan_two_o = m[1] ? d : data_chan_two_o;
      tick;
      {write_strobe_chan_two_o, write_strobe_chan_one_o} = m;
      tick;
      {write_strobe_chan_two_o, write_strobe_chan_one_o} = 2'b00;
      // bus is inverted once held, so a stale word cannot pass
      {data_chan_two_o, data_chan_one_o} = ~{data_chan_two_o, data_chan_one_o};
      tick;
   endtask
   // one word on the shared bus; its falling strobe forwards the latches
   task automatic iq_word(input logic s, input logic [11:0] d);
      channel_select_o = s;
      data_chan_one_o = d;
      data_chan_two_o = ~d; // second bus carries junk here
      tick;
      shared_write_strobe_o = 1'b1;
      tick;
      shared_write_strobe_o = 1'b0;
      data_chan_one_o = ~d;
      tick;
   endtask
   task automatic pulse_clk;
      shared_update_clock_o = 1'b1;
      tick;
      shared_update_clock_o = 1'b0;
      tick;
   endtask
   // i then q, one clock rise after each word but the first i word since alignment, divided rise after the q word
   task automatic iq_pair(input logic [11:0] i, input logic [11:0] q);
      iq_word(1'b1, i);
      if (ph)
         pulse_clk;
      iq_word(1'b0, q);
      pulse_clk;
      ph = 1'b1;
   endtask
endmodule // ddi_host
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench of the converter input front end
// assumes ddi_top with default buffer depth and a 20 MHz block clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk_i;   // block clock
   logic        rst_n_i; // reset, low active
   logic        rdy;     // drain side ready
   wire  logic  mode, wr1, wr2, uc1, uc2, wrs, ucs, sel, aln;
   wire  logic [11:0] d1, d2, ci, cq, oi, oq;
   wire  logic  ov, ui, uq, cu, dc, hr;
   int          fails = 0;
   int          checks = 0;
   int          nupd = 0; // latch updates seen
   logic [11:0] pat [8] = '{12'hfff, 12'h000, 12'h800, 12'h7ff, 12'h001, 12'h5a5, 12'ha5a, 12'hffe};
   ddi_host host (.clk_i(clk_i), .host_ready_i(hr), .mode_dual_o(mode), .data_chan_one_o(d1),
      .data_chan_two_o(d2), .write_strobe_chan_one_o(wr1), .write_strobe_chan_two_o(wr2),
      .update_clock_chan_one_o(uc1), .update_clock_chan_two_o(uc2),
      .shared_write_strobe_o(wrs), .shared_update_clock_o(ucs), .channel_select_o(sel),
      .interleave_align_reset_o(aln));
   ddi_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .mode_dual_i(mode), .data_chan_one_i(d1),
      .data_chan_two_i(d2), .write_strobe_chan_one_i(wr1), .write_strobe_chan_two_i(wr2),
      .update_clock_chan_one_i(uc1), .update_clock_chan_two_i(uc2),
      .shared_write_strobe_i(wrs), .shared_update_clock_i(ucs), .channel_select_i(sel),
      .interleave_align_reset_i(aln), .out_ready_i(rdy), .out_valid_o(ov), .out_data_i_o(oi),
      .out_data_q_o(oq), .out_upd_i_o(ui), .out_upd_q_o(uq), .conv_i_o(ci), .conv_q_o(cq),
      .conv_update_o(cu), .divided_converter_clock_o(dc), .host_ready_o(hr));
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
      if (cu === 1'b1)
         nupd <= nupd + 1;
   task automatic cmp(input logic [11:0] e, input logic [11:0] g);
      checks = checks + 1;
      if (g !== e)
      begin
         fails = fails + 1;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic results;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // strap moves only while reset holds the block
   task automatic do_reset(input logic m);
      rst_n_i = 1'b0;
      host.mode_dual_o = m;
      repeat (5) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (2) @(negedge clk_i);
   endtask
   // channels written alternately, channel one must not move on the channel two strobe
   task automatic t_dual;
      int k;
      do_reset(1'b1);
      for (k = 0; k < 8; k++)
      begin
         host.dual_word(2'b01, pat[k]);
         cmp(k < 4 ? 12'h000 : pat[k-4], ci);
         host.dual_word(2'b10, pat[7-k]);
         cmp(k < 4 ? 12'h000 : pat[11-k], cq);
         cmp(k < 4 ? 12'h000 : pat[k-4], ci);
      end
   endtask
   // fill the buffer with the drain stalled, then empty it in order
   task automatic t_buffer;
      int k;
      int n;
      do_reset(1'b1);
      rdy = 1'b0;
      for (k = 0; k < 16; k++)
         host.dual_word(2'b01, pat[k % 8]);
      cmp(12'h000, {11'h000, hr});
      rdy = 1'b1;
      n = 0;
      repeat (40)
      begin
         if (ov === 1'b1)
         begin
            cmp(n < 4 ? 12'h000 : pat[(n - 4) % 8], oi);
            cmp(12'h001, {10'h000, uq, ui});
            cmp(12'h000, oq);
            n = n + 1;
         end
         @(negedge clk_i);
      end
      cmp(12'd16, 12'(n));
   endtask
   // alignment holds the divided clock, then pairs flow four rises deep
   task automatic t_iq;
      int k;
      int n0;
      do_reset(1'b0);
      host.interleave_align_reset_o = 1'b1;
      host.ph = 1'b0;
      n0 = nupd;
      repeat (2) host.pulse_clk;
      cmp({11'h000, dc}, 12'h000);
      cmp(12'(nupd - n0), 12'h000);
      host.interleave_align_reset_o = 1'b0;
      for (k = 0; k < 6; k++)
      begin
         host.iq_pair(pat[k], pat[7-k]);
         cmp({11'h000, dc}, 12'h001);
         cmp(k < 3 ? 12'h000 : pat[k-3], ci);
         cmp(k < 3 ? 12'h000 : pat[10-k], cq);
      end
      cmp(12'd6, 12'(nupd - n0));
   endtask
   initial
   begin
      rdy = 1'b1;
      t_dual;
      t_buffer;
      t_iq;
      results;
   end
   // the run needs about 505 clocks, far below this limit
   initial
   begin
      #200us;
      fails = fails + 1;
      results;
   end
endmodule // tb_top
`default_nettype wire
